// >>> pkg/ccc_consts.svh
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH

// Register bus geometry
`define CCC_ADDR_W 4
`define CCC_DATA_W 16

// Register indices on the plain register port
`define CCC_ADDR_CFG 4'h0
`define CCC_ADDR_VALH 4'h1
`define CCC_ADDR_VALL 4'h2

// Field positions of the configuration and calibration register
`define CCC_BIT_ENABLE 15
`define CCC_BIT_UNLOCK 13
`define CCC_BIT_HAZARD 12
`define CCC_BIT_HALF 11
`define CCC_BIT_OE 10
`define CCC_PTR_HI 9
`define CCC_PTR_LO 8
`define CCC_CAL_HI 7
`define CCC_CAL_LO 0

// Reset values
`define CCC_CAL_RESET 8'h00
`define CCC_PTR_RESET 2'h0
`define CCC_WORD_RESET 16'h0000

// Value window geometry
`define CCC_WIN_WORDS 4
`define CCC_WIN_IDX_W 2

`endif

// >>> pkg/ccc_pkg.sv
package ccc_pkg;

    // Window pointer codes; upper byte / lower byte of the selected word
    typedef enum logic [1:0]
    {
        CCC_PTR_MIN_SEC = 2'b00,
        CCC_PTR_WDAY_HOUR = 2'b01,
        CCC_PTR_MONTH_DAY = 2'b10,
        CCC_PTR_RSVD_YEAR = 2'b11
    } ccc_ptr_t;

    // Source of the next word on the read data register
    typedef enum logic [1:0]
    {
        CCC_RD_NONE = 2'b00,
        CCC_RD_CFG = 2'b01,
        CCC_RD_WIN = 2'b10
    } ccc_rd_src_t;

endpackage

// >>> pkg/ccc_win_if.sv
`timescale 1ns/10ps

interface ccc_win_if;
    import ccc_pkg::*;

    // Write side of the value store
    logic wr_en;
    logic [1:0] wr_idx;
    logic [15:0] wr_data;
    // Read side; the store registers the selected word
    ccc_rd_src_t rd_src;
    logic [1:0] rd_idx;
    logic [15:0] cfg_word;
    logic [15:0] rd_data;

    modport ctrl
    (
        output wr_en,
        output wr_idx,
        output wr_data,
        output rd_src,
        output rd_idx,
        output cfg_word,
        input rd_data
    );

    modport store
    (
        input wr_en,
        input wr_idx,
        input wr_data,
        input rd_src,
        input rd_idx,
        input cfg_word,
        output rd_data
    );
endinterface

// >>> hw/ccc_value_store.sv
`timescale 1ns/10ps
`include "ccc_consts.svh"

module ccc_value_store
    import ccc_pkg::*;
#(
    parameter int WORDS = `CCC_WIN_WORDS
)
(
    // Clock and power-on reset
    input wire logic clock,
    input wire logic reset,
    // Link to the control logic
    ccc_win_if.store win
);

    logic [15:0] word_mem [WORDS];
    logic [15:0] rd_data_reg;

    // Time field words; cleared only by the power-on reset
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                word_mem[i] <= `CCC_WORD_RESET;
            end
        end
        else if (win.wr_en)
        begin
            word_mem[win.wr_idx] <= win.wr_data;
        end
    end

    // Registered read; the reserved upper byte of code 11 reads as zero
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rd_data_reg <= `CCC_WORD_RESET;
        end
        else
        begin
            case (win.rd_src)
                CCC_RD_CFG: rd_data_reg <= win.cfg_word;
                CCC_RD_WIN:
                begin
                    if (win.rd_idx == CCC_PTR_RSVD_YEAR)
                    begin
                        rd_data_reg <= {8'h00, word_mem[win.rd_idx][7:0]};
                    end
                    else
                    begin
                        rd_data_reg <= word_mem[win.rd_idx];
                    end
                end
                default: rd_data_reg <= `CCC_WORD_RESET;
            endcase
        end
    end

    assign win.rd_data = rd_data_reg;

endmodule

// >>> hw/ccc_config_window.sv
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "ccc_consts.svh"

module ccc_config_window
    import ccc_pkg::*;
#(
    parameter int ADDR_W = `CCC_ADDR_W,
    parameter int DATA_W = `CCC_DATA_W
)
(
    // Clock and power-on reset
    input wire logic clock,
    input wire logic reset,

    // Register port
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [DATA_W-1:0] read_data,

    // Status from the timekeeping counters
    input wire logic half_second_tick,
    input wire logic rollover_ripple,

    // Controls to the timekeeping counters and output pin
    output logic clock_unit_enable,
    output logic clock_output_enable,
    output logic [7:0] calibration,
    output logic value_write_unlock
);

    // Address decode used by both the write and read paths
    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
        is_addr = (a == target);
    endfunction

    // Pointer step: count down, hold at zero
    function automatic logic [1:0] ptr_step(input logic [1:0] p);
        if (p == 2'b00)
        begin
            ptr_step = 2'b00;
        end
        else
        begin
            ptr_step = p - 2'b01;
        end
    endfunction

    ccc_win_if win ();

    logic clock_unit_enable_reg;
    logic value_write_unlock_reg;
    logic rollover_read_hazard_reg;
    logic half_second_phase_reg;
    logic clock_output_enable_reg;
    logic [1:0] value_window_pointer_reg;
    logic [1:0] value_window_pointer_next;
    logic [7:0] calibration_reg;

    logic cfg_wr;
    logic valh_wr;
    logic vall_wr;
    logic valh_rd;
    logic vall_rd;
    logic win_wr_ok;
    logic high_access;
    logic min_sec_low_wr;
    logic [15:0] cfg_word;

    // Strobe decode
    always_comb
    begin
        cfg_wr = write_strobe && is_addr(address, `CCC_ADDR_CFG);
        valh_wr = write_strobe && is_addr(address, `CCC_ADDR_VALH);
        vall_wr = write_strobe && is_addr(address, `CCC_ADDR_VALL);
        valh_rd = read_strobe && is_addr(address, `CCC_ADDR_VALH);
        vall_rd = read_strobe && is_addr(address, `CCC_ADDR_VALL);
    end

    // Window writes pass only while unlocked
    always_comb
    begin
        win_wr_ok = (valh_wr || vall_wr) && value_write_unlock_reg;
        high_access = valh_rd || valh_wr;
        // Lower half of the minutes-seconds word is the seconds byte at code 00
        min_sec_low_wr = win_wr_ok && (value_window_pointer_reg == CCC_PTR_MIN_SEC);
    end

    // Enable bit; the check uses the unlock bit as it stands before this write
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            clock_unit_enable_reg <= 1'b0;
        end
        else if (cfg_wr && value_write_unlock_reg)
        begin
            clock_unit_enable_reg <= write_data[`CCC_BIT_ENABLE];
        end
    end

    // Unlock bit, free to write at any time
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            value_write_unlock_reg <= 1'b0;
        end
        else if (cfg_wr)
        begin
            value_write_unlock_reg <= write_data[`CCC_BIT_UNLOCK];
        end
    end

    // Output enable for the clock unit's output signal
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            clock_output_enable_reg <= 1'b0;
        end
        else if (cfg_wr)
        begin
            clock_output_enable_reg <= write_data[`CCC_BIT_OE];
        end
    end

    // Calibration byte, stored and returned unchanged
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            calibration_reg <= `CCC_CAL_RESET;
        end
        else if (cfg_wr)
        begin
            calibration_reg <= write_data[`CCC_CAL_HI:`CCC_CAL_LO];
        end
    end

    // Pointer: a direct write wins over the auto-decrement of the same cycle
    always_comb
    begin
        value_window_pointer_next = value_window_pointer_reg;
        if (cfg_wr)
        begin
            value_window_pointer_next = write_data[`CCC_PTR_HI:`CCC_PTR_LO];
        end
        else if (high_access)
        begin
            // A locked-out write still counts as an access of the high window
            value_window_pointer_next = ptr_step(value_window_pointer_reg);
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            value_window_pointer_reg <= `CCC_PTR_RESET;
        end
        else
        begin
            value_window_pointer_reg <= value_window_pointer_next;
        end
    end

    // Half-second phase toggles on each half-second tick while running
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            half_second_phase_reg <= 1'b0;
        end
        else if (min_sec_low_wr)
        begin
            // Realigns the phase with freshly written seconds
            half_second_phase_reg <= 1'b0;
        end
        else if (clock_unit_enable_reg && half_second_tick)
        begin
            half_second_phase_reg <= ~half_second_phase_reg;
        end
    end

    // Hazard flag follows the counters' ripple window, only while running
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rollover_read_hazard_reg <= 1'b0;
        end
        else
        begin
            // One cycle late, so it rises with the counters, not ahead of them
            rollover_read_hazard_reg <= clock_unit_enable_reg && rollover_ripple;
        end
    end

    // Word presented on a configuration read
    always_comb
    begin
        cfg_word = 16'h0000;
        cfg_word[`CCC_BIT_ENABLE] = clock_unit_enable_reg;
        cfg_word[`CCC_BIT_UNLOCK] = value_write_unlock_reg;
        cfg_word[`CCC_BIT_HAZARD] = rollover_read_hazard_reg;
        cfg_word[`CCC_BIT_HALF] = half_second_phase_reg;
        cfg_word[`CCC_BIT_OE] = clock_output_enable_reg;
        cfg_word[`CCC_PTR_HI:`CCC_PTR_LO] = value_window_pointer_reg;
        cfg_word[`CCC_CAL_HI:`CCC_CAL_LO] = calibration_reg;
    end

    // Drive the value store: write and read both use the current pointer
    always_comb
    begin
        win.wr_en = win_wr_ok;
        win.wr_idx = value_window_pointer_reg;
        win.wr_data = write_data;
        win.rd_idx = value_window_pointer_reg;
        win.cfg_word = cfg_word;
        if (read_strobe && is_addr(address, `CCC_ADDR_CFG))
        begin
            win.rd_src = CCC_RD_CFG;
        end
        else if (valh_rd || vall_rd)
        begin
            win.rd_src = CCC_RD_WIN;
        end
        else
        begin
            // Unmapped reads and idle cycles return zero
            win.rd_src = CCC_RD_NONE;
        end
    end

    // Time field store; its read register is the read data output
    ccc_value_store #(
        .WORDS(`CCC_WIN_WORDS)
    ) u_store (
        .clock(clock),
        .reset(reset),
        .win(win)
    );

    // Outputs straight from flip-flops
    assign read_data = win.rd_data;
    assign clock_unit_enable = clock_unit_enable_reg;
    assign clock_output_enable = clock_output_enable_reg;
    assign calibration = calibration_reg;
    assign value_write_unlock = value_write_unlock_reg;

endmodule

// >>> verif/ccc_config_window_monitor.sv
`timescale 1ns/10ps
`include "ccc_consts.svh"

module ccc_config_window_monitor
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [DATA_W-1:0] read_data,
    // Counter status and controls
    input wire logic half_second_tick,
    input wire logic rollover_ripple,
    input wire logic clock_unit_enable,
    input wire logic clock_output_enable,
    input wire logic [7:0] calibration,
    input wire logic value_write_unlock
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // Decoded configuration accesses, and cycles with no tick and no write strobe
    logic cfg_wr;
    logic cfg_rd;
    logic quiet;
    assign cfg_wr = write_strobe && address == `CCC_ADDR_CFG;
    assign cfg_rd = read_strobe && address == `CCC_ADDR_CFG;
    assign quiet = !half_second_tick && !write_strobe;

    // Three steady cycles hide the one-cycle lag of the hazard flag
    sequence s_ripple_on;
        (rollover_ripple && clock_unit_enable) [*3] ##0 cfg_rd;
    endsequence
    sequence s_ripple_off;
        (!rollover_ripple) [*3] ##0 cfg_rd;
    endsequence
    // Two reads with nothing in between that could move the half bit
    sequence s_quiet_pair;
        (cfg_rd && quiet) ##1 quiet ##1 (cfg_rd && quiet);
    endsequence

    a_enable_locked: assert property (cfg_wr && !value_write_unlock |=>
        clock_unit_enable == $past(clock_unit_enable)) else $error("enable moved while locked");
    a_enable_write: assert property (cfg_wr && value_write_unlock |=>
        clock_unit_enable == $past(write_data[15])) else $error("enable not written");
    a_output_enable: assert property (cfg_wr |=>
        clock_output_enable == $past(write_data[10])) else $error("output enable not written");
    a_cal_store: assert property (cfg_wr |=> calibration == $past(write_data[7:0]))
        else $error("calibration not written");
    a_unlock_store: assert property (cfg_wr |=> value_write_unlock == $past(write_data[13]))
        else $error("unlock not written");
    a_cfg_readback: assert property (cfg_rd |=> read_data[15] == $past(clock_unit_enable)
        && read_data[14] == 1'b0 && read_data[13] == $past(value_write_unlock)
        && read_data[10] == $past(clock_output_enable) && read_data[7:0] == $past(calibration))
        else $error("configuration read back wrong");
    a_hazard_set: assert property (s_ripple_on |=> read_data[12])
        else $error("hazard flag missing");
    a_hazard_clear: assert property (s_ripple_off |=> !read_data[12])
        else $error("hazard flag stuck");
    a_half_steady: assert property (s_quiet_pair |=> read_data[11] == $past(read_data[11], 2))
        else $error("half bit moved without tick");
endmodule

bind ccc_config_window ccc_config_window_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_monitor
(
    .clock(clock),
    .reset(reset),
    .address(address),
    .write_data(write_data),
    .write_strobe(write_strobe),
    .read_strobe(read_strobe),
    .read_data(read_data),
    .half_second_tick(half_second_tick),
    .rollover_ripple(rollover_ripple),
    .clock_unit_enable(clock_unit_enable),
    .clock_output_enable(clock_output_enable),
    .calibration(calibration),
    .value_write_unlock(value_write_unlock)
);

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`include "ccc_consts.svh"

module tb_top;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] address = 4'h0;
    logic [15:0] write_data = 16'h0000;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic half_second_tick = 1'b0;
    logic rollover_ripple = 1'b0;
    logic [15:0] read_data;
    logic clock_unit_enable;
    logic clock_output_enable;
    logic value_write_unlock;
    logic [7:0] calibration;
    logic [15:0] ctl;
    logic [15:0] got;
    logic [15:0] first_read;
    logic [15:0] win [4] = '{16'h4559, 16'h0317, 16'h1231, 16'h5a24};
    int miscompares = 0;
    int tests_run = 0;
    int i;

    assign ctl = {5'h00, clock_unit_enable, clock_output_enable, value_write_unlock, calibration};

    ccc_config_window i_dut
    (
        .clock(clock),
        .reset(reset),
        .address(address),
        .write_data(write_data),
        .write_strobe(write_strobe),
        .read_strobe(read_strobe),
        .read_data(read_data),
        .half_second_tick(half_second_tick),
        .rollover_ripple(rollover_ripple),
        .clock_unit_enable(clock_unit_enable),
        .clock_output_enable(clock_output_enable),
        .calibration(calibration),
        .value_write_unlock(value_write_unlock)
    );

    // 40 MHz clock
    initial
    begin
        forever #12.5 clock = ~clock;
    end

    task conclude;
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task ck(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            miscompares++;
        end
    endtask

    // One-cycle strobes, changed just after the edge
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 got = read_data;
    endtask

    task tick;
        @(posedge clock);
        half_second_tick <= 1'b1;
        @(posedge clock);
        half_second_tick <= 1'b0;
    endtask

    // Hold the ripple long enough for the registered flag to follow
    task ripple(input logic v);
        @(posedge clock);
        rollover_ripple <= v;
        repeat (3) @(posedge clock);
    endtask

    task t_reset;
        rd(`CCC_ADDR_CFG);
        ck(got, 16'h0000);
        ck(ctl, 16'h0000);
    endtask

    task t_enable;
        wr(`CCC_ADDR_CFG, 16'h84c5);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'h04c5);
        ck(ctl, 16'h02c5);
        wr(`CCC_ADDR_CFG, 16'ha4c5);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'h24c5);
        wr(`CCC_ADDR_CFG, 16'ha4c5);
        rd(`CCC_ADDR_CFG);
        ck(ctl, 16'h07c5);
        wr(`CCC_ADDR_CFG, 16'h2000);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'h2000);
    endtask

    task t_window;
        wr(`CCC_ADDR_CFG, 16'h2300);
        for (i = 3; i >= 0; i--)
            wr(`CCC_ADDR_VALH, win[i]);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'h2000);
        wr(`CCC_ADDR_CFG, 16'h2300);
        for (i = 3; i >= 0; i--)
        begin
            rd(`CCC_ADDR_VALH);
            ck(got, i == 3 ? {8'h00, win[3][7:0]} : win[i]);
        end
        rd(`CCC_ADDR_VALH);
        ck(got, win[0]);
        wr(`CCC_ADDR_CFG, 16'h2200);
        rd(`CCC_ADDR_VALL);
        rd(`CCC_ADDR_VALL);
        ck(got, win[2]);
    endtask

    // Locked writes are dropped; a locked high-window write still steps the pointer, a low-window one does not
    task t_locked;
        wr(`CCC_ADDR_CFG, 16'h0200);
        wr(`CCC_ADDR_VALH, 16'hffff);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'h0100);
        wr(`CCC_ADDR_VALL, 16'hffff);
        rd(`CCC_ADDR_VALL);
        ck(got, win[1]);
        wr(`CCC_ADDR_CFG, 16'h0200);
        rd(`CCC_ADDR_VALH);
        ck(got, win[2]);
    endtask

    task t_half;
        wr(`CCC_ADDR_CFG, 16'h2000);
        wr(`CCC_ADDR_CFG, 16'ha000);
        tick;
        rd(`CCC_ADDR_CFG);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'ha800);
        tick;
        rd(`CCC_ADDR_CFG);
        ck(got, 16'ha000);
        tick;
        wr(`CCC_ADDR_VALL, 16'h0000);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'ha000);
    endtask

    // Seconds word loaded first so the double read has a known value
    task t_hazard;
        wr(`CCC_ADDR_VALL, win[0]);
        ripple(1'b1);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'hb000);
        // While the flag stands, software trusts only two matching reads
        rd(`CCC_ADDR_VALL);
        first_read = got;
        rd(`CCC_ADDR_VALL);
        ck(first_read, win[0]);
        ck(got, win[0]);
        ripple(1'b0);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'ha000);
        wr(`CCC_ADDR_CFG, 16'h2000);
        ripple(1'b1);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'h2000);
        ripple(1'b0);
    endtask

    task t_unmapped;
        wr(4'hf, 16'hffff);
        rd(4'hf);
        ck(got, 16'h0000);
        rd(`CCC_ADDR_CFG);
        ck(got, 16'h2000);
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        t_reset;
        t_enable;
        t_window;
        t_locked;
        t_half;
        t_hazard;
        t_unmapped;
        conclude;
    end

    // Run needs well under a thousand cycles
    initial
    begin
        #200000;
        miscompares++;
        conclude;
    end
endmodule
